// file: pccc_ctrl.sv
// Purpose: power sequencing and battery charge port controller
// Assumes: pins are asynchronous and pass two flops; one clock domain
// Notes: charge intervals count seconds from a prescaled tick
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - normal charge first interval after adapter connect
// - trickle after interval while adapter stays
// - bypass jumper forces normal charge with adapter
// - power switch edges raise off/on events
// - sense enable high routes battery to converter
// - host reset output is active low
// - backup select low main, high auxiliary
// - reset switch low asserts host and array reset
// - adapter detect high means adapter present
// - gate array initialise output active low
// - logic power enable low turns supply on
// - low voltage holds aux normal charge 8 hours
// - battery at or below 5 V restarts normal
// - interval 11 hours if logic on at connect
module pccc_ctrl
  import pccc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // pins in
  input wire logic power_switch_irq_in,
  input wire logic reset_switch_n,
  input wire logic adapter_present,
  input wire logic charge_control_bypass,
  input wire logic batt_at_or_below_5v,
  input wire logic low_voltage_detect,
  // pins out
  output logic battery_sense_enable,
  output logic host_reset_n,
  output logic main_charge_mode,
  output logic backup_battery_select,
  output logic aux_charge_mode,
  output logic logic_power_enable_n,
  output logic gate_array_init_n
);
  if (TICK_CYCLES < 1) begin : g_chk
    $error("pccc_ctrl: TICK_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edges
  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic [IN_W-1:0] prev_reg;
  logic [IN_W-1:0] rise;
  logic [IN_W-1:0] fall;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_reg <= IN_RST;
      sync2_reg <= IN_RST;
      prev_reg <= IN_RST;
    end else begin
      sync1_reg <= {low_voltage_detect, batt_at_or_below_5v, charge_control_bypass,
                    adapter_present, reset_switch_n, power_switch_irq_in};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  logic adp;
  logic byp;
  assign adp = sync2_reg[IN_ADAPTER];
  assign byp = sync2_reg[IN_BYPASS];

  ////////////////////////////////////////////////////////////////////////////
  // one second time base
  logic [31:0] pre_reg;
  logic tick;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else if (pre_reg == 32'(TICK_CYCLES - 1)) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  assign tick = (pre_reg == 32'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  logic [CTRL_W-1:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  logic wr_ok;
  logic [DATA_W-1:0] rd_next;
  logic main_run;
  logic aux_run;
  logic [SEC_W-1:0] main_sec;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  // a write lands only on the edge where the master sees waitrequest low
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_comb begin
    rd_next = '0;
    if (hit(avs_address, OFS_CTRL)) begin
      rd_next = DATA_W'(ctrl_reg);
    end else if (hit(avs_address, OFS_STATUS)) begin
      rd_next = DATA_W'({aux_charge_mode, main_charge_mode, sync2_reg[IN_BATT_LOW5], byp,
                         adp, sync2_reg[IN_RST_SW_N], sync2_reg[IN_PWR_SW]});
    end else if (hit(avs_address, OFS_IRQ_STAT)) begin
      rd_next = DATA_W'(irq_stat_reg);
    end else if (hit(avs_address, OFS_IRQ_MASK)) begin
      rd_next = DATA_W'(irq_mask_reg);
    end else if (hit(avs_address, OFS_CHG_SEC)) begin
      rd_next = DATA_W'(main_sec);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ok && hit(avs_address, OFS_CTRL)) begin
      ctrl_reg <= avs_writedata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_mask_reg <= IRQ_RST;
    end else if (wr_ok && hit(avs_address, OFS_IRQ_MASK)) begin
      irq_mask_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt
  logic main_run_prev_reg;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      main_run_prev_reg <= 1'b0;
    end else begin
      main_run_prev_reg <= main_run;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_PWR_ON] = rise[IN_PWR_SW];
    irq_event[IRQ_PWR_OFF] = fall[IN_PWR_SW];
    irq_event[IRQ_ADP_IN] = rise[IN_ADAPTER];
    irq_event[IRQ_ADP_OUT] = fall[IN_ADAPTER];
    irq_event[IRQ_RST_SW] = fall[IN_RST_SW_N];
    irq_event[IRQ_CHG_DONE] = main_run_prev_reg && !main_run && adp;
  end

  // a new event beats a same-cycle write-one-to-clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_stat_reg <= IRQ_RST;
    end else if (wr_ok && hit(avs_address, OFS_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge timers
  logic main_start;
  logic [SEC_W-1:0] main_limit_reg;

  // a drop to the 5 V limit with the adapter in restarts the normal charge
  assign main_start = rise[IN_ADAPTER] || (adp && rise[IN_BATT_LOW5]);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      main_limit_reg <= CHG_NORMAL_SEC;
    end else if (main_start) begin
      main_limit_reg <= ctrl_reg[CTRL_LOGIC_ON] ? CHG_LOGIC_ON_SEC : CHG_NORMAL_SEC;
    end
  end

  pccc_sec_timer #(
    .W(SEC_W)
  ) u_main_timer (
    .mclk(mclk),
    .nrst(nrst),
    .start(main_start),
    .stop(fall[IN_ADAPTER]),
    .tick(tick),
    .limit(main_limit_reg),
    .running_reg(main_run),
    .elapsed_reg(main_sec)
  );

  pccc_sec_timer #(
    .W(SEC_W)
  ) u_aux_timer (
    .mclk(mclk),
    .nrst(nrst),
    .start(rise[IN_LOW_VOLT]),
    .stop(1'b0),
    .tick(tick),
    .limit(AUX_NORMAL_SEC),
    .running_reg(aux_run),
    .elapsed_reg()
  );

  ////////////////////////////////////////////////////////////////////////////
  // output pins
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      main_charge_mode <= 1'b1;
      aux_charge_mode <= 1'b1;
    end else begin
      main_charge_mode <= !(adp && (byp || main_run));
      aux_charge_mode <= !aux_run;
    end
  end

  // the reset switch overrides software so a hung host can be recovered
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      host_reset_n <= 1'b0;
      gate_array_init_n <= 1'b0;
    end else begin
      host_reset_n <= ctrl_reg[CTRL_HOST_RUN] && sync2_reg[IN_RST_SW_N];
      gate_array_init_n <= ctrl_reg[CTRL_GA_RUN] && sync2_reg[IN_RST_SW_N];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      logic_power_enable_n <= 1'b1;
      battery_sense_enable <= 1'b0;
      backup_battery_select <= 1'b0;
    end else begin
      logic_power_enable_n <= !ctrl_reg[CTRL_LOGIC_ON];
      battery_sense_enable <= ctrl_reg[CTRL_SENSE];
      backup_battery_select <= ctrl_reg[CTRL_BACKUP_AUX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  AST_NORMAL_HOLD: assert property ((adp && !byp && main_run) |=> !main_charge_mode)
    else $error("main charge not normal during interval");
  AST_TRICKLE: assert property (($fell(main_run) && adp && !byp) |=> main_charge_mode)
    else $error("main charge not trickle after interval");
  AST_BYPASS: assert property ((adp && byp) |=> !main_charge_mode)
    else $error("bypass did not force normal charge");
  AST_PWR_EDGE: assert property (rise[IN_PWR_SW] |=> irq_stat_reg[IRQ_PWR_ON])
    else $error("power switch on edge lost");
  AST_PWR_OFF: assert property (fall[IN_PWR_SW] |=> irq_stat_reg[IRQ_PWR_OFF])
    else $error("power switch off edge lost");
  AST_SENSE: assert property ((wr_ok && hit(avs_address, OFS_CTRL))
    |=> ##1 (battery_sense_enable == $past(avs_writedata[CTRL_SENSE], 2)))
    else $error("sense enable does not follow write");
  AST_RESET_SW: assert property (!sync2_reg[IN_RST_SW_N]
    |=> (!host_reset_n && !gate_array_init_n))
    else $error("reset switch did not reset host and arrays");
  AST_BACKUP: assert property (ctrl_reg[CTRL_BACKUP_AUX] [*2] |-> backup_battery_select)
    else $error("backup select not auxiliary");
  AST_LOGIC_OFF: assert property (!ctrl_reg[CTRL_LOGIC_ON] |=> logic_power_enable_n)
    else $error("logic power on without request");
  AST_AUX_NORMAL: assert property (rise[IN_LOW_VOLT] |-> ##2 !aux_charge_mode)
    else $error("aux normal charge not started");
  AST_ADP_REMOVE: assert property ($fell(adp) |=> ##1 (!main_run && main_charge_mode))
    else $error("timer kept running after adapter removal");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  COV_CHG_DONE: cover property (irq_event[IRQ_CHG_DONE]);
  COV_RESTART: cover property (adp && rise[IN_BATT_LOW5]);
  COV_RST_SW: cover property (fall[IN_RST_SW_N] ##[1:4] !host_reset_n);
  COV_IRQ: cover property ($rose(irq));
endmodule : pccc_ctrl

// file: pccc_far_side.sv
// Purpose: far-side world of the port controller: switches, adapter, jumper, battery
// Assumes: commands change by non-blocking assignment just after a rising mclk edge
// Notes: SLOW adds one edge of contact lag to every pin
module pccc_far_side #(
  parameter bit SLOW = 1'b0
) (
  // clock
  input wire logic mclk,
  // commanded world state
  input wire logic sw_on,
  input wire logic rst_press,
  input wire logic plug,
  input wire logic jumper,
  input wire logic batt_low,
  input wire logic low_volt,
  // controller side
  input wire logic main_charge_mode,
  output logic power_switch_irq_in,
  output logic reset_switch_n,
  output logic adapter_present,
  output logic charge_control_bypass,
  output logic batt_at_or_below_5v,
  output logic low_voltage_detect,
  // charge network
  output logic normal_charging
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cmd;
  logic [5:0] lag_reg = 6'h02;
  logic [5:0] pin_reg = 6'h02;
  ////////////////////////////////////////////////////////////////////////////////
  assign cmd = {low_volt, batt_low, jumper, plug, !rst_press, sw_on};
  always_ff @(posedge mclk) begin
    lag_reg <= cmd;
    pin_reg <= SLOW ? lag_reg : cmd;
  end
  assign {low_voltage_detect, batt_at_or_below_5v, charge_control_bypass} = pin_reg[5:3];
  assign {adapter_present, reset_switch_n, power_switch_irq_in} = pin_reg[2:0];
  // a fitted jumper shorts the mode transistor, so the mode pin no longer matters
  assign normal_charging = adapter_present & (charge_control_bypass | !main_charge_mode);
endmodule : pccc_far_side

// file: pccc_pkg.sv
// Purpose: shared constants for the power and charge port controller
// Assumes: 250 MHz mclk, Avalon-MM register slave with 32-bit data
// Notes: register offsets are byte addresses, one word each
package pccc_pkg;
  // clock and time base
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_SEC = 1;
  localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_SEC;
  localparam int SEC_PER_HOUR = 3600;
  localparam int CHG_NORMAL_HOURS = 8;
  localparam int CHG_LOGIC_ON_HOURS = 11;
  localparam int AUX_NORMAL_HOURS = 8;
  localparam int SEC_W = 16;
  localparam logic [SEC_W-1:0] CHG_NORMAL_SEC = SEC_W'(CHG_NORMAL_HOURS * SEC_PER_HOUR);
  localparam logic [SEC_W-1:0] CHG_LOGIC_ON_SEC = SEC_W'(CHG_LOGIC_ON_HOURS * SEC_PER_HOUR);
  localparam logic [SEC_W-1:0] AUX_NORMAL_SEC = SEC_W'(AUX_NORMAL_HOURS * SEC_PER_HOUR);

  // bus
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CHG_SEC = 5'h10;

  // control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_LOGIC_ON = 0;
  localparam int CTRL_HOST_RUN = 1;
  localparam int CTRL_GA_RUN = 2;
  localparam int CTRL_SENSE = 3;
  localparam int CTRL_BACKUP_AUX = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // synchronised input vector positions
  localparam int IN_W = 6;
  localparam int IN_PWR_SW = 0;
  localparam int IN_RST_SW_N = 1;
  localparam int IN_ADAPTER = 2;
  localparam int IN_BYPASS = 3;
  localparam int IN_BATT_LOW5 = 4;
  localparam int IN_LOW_VOLT = 5;
  localparam logic [IN_W-1:0] IN_RST = 6'h02;

  // interrupt status fields
  localparam int IRQ_W = 6;
  localparam int IRQ_PWR_ON = 0;
  localparam int IRQ_PWR_OFF = 1;
  localparam int IRQ_ADP_IN = 2;
  localparam int IRQ_ADP_OUT = 3;
  localparam int IRQ_RST_SW = 4;
  localparam int IRQ_CHG_DONE = 5;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
endpackage : pccc_pkg

// file: pccc_sec_timer.sv
// Purpose: seconds interval timer, restartable, stops at its limit
// Assumes: tick is a one-cycle pulse from the same clock
// Notes: start wins over stop when both arrive together
module pccc_sec_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // state
  output logic running_reg,
  output logic [W-1:0] elapsed_reg
);
  if (W < 1) begin : g_chk
    $error("pccc_sec_timer: W must be at least 1");
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      running_reg <= 1'b0;
      elapsed_reg <= '0;
    end else if (start) begin
      running_reg <= 1'b1;
      elapsed_reg <= '0;
    end else if (stop) begin
      running_reg <= 1'b0;
    end else if (tick && running_reg) begin
      if (elapsed_reg == limit - W'(1)) begin
        running_reg <= 1'b0;
      end
      elapsed_reg <= elapsed_reg + W'(1);
    end
  end
endmodule : pccc_sec_timer

// file: test_power_charge_port_controller.sv
// Purpose: self-checking bench for the power and charge port controller
// Assumes: TICK_CYCLES of 1, so an interval of N seconds lasts N mclk cycles
// Notes: pin vector is {ga_n, lp_n, aux, backup, main, host_n, sense}
module test_power_charge_port_controller
  import pccc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic sw_on = 1'b0;
  logic rst_press = 1'b0;
  logic plug = 1'b0;
  logic jumper = 1'b0;
  logic batt_low = 1'b0;
  logic low_volt = 1'b0;
  logic pwr_sw, rst_sw_n, adp, byp, b5v, lvd, nchg;
  logic sense, host_n, main_mode, bkp, aux_mode, lp_n, ga_n;
  logic [31:0] pins;
  logic [31:0] rd;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  assign pins = {25'h0, ga_n, lp_n, aux_mode, bkp, main_mode, host_n, sense};
  ////////////////////////////////////////////////////////////////////////////////
  pccc_ctrl #(.TICK_CYCLES(1)) uut (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .power_switch_irq_in(pwr_sw), .reset_switch_n(rst_sw_n), .adapter_present(adp),
    .charge_control_bypass(byp), .batt_at_or_below_5v(b5v), .low_voltage_detect(lvd),
    .battery_sense_enable(sense), .host_reset_n(host_n), .main_charge_mode(main_mode),
    .backup_battery_select(bkp), .aux_charge_mode(aux_mode), .logic_power_enable_n(lp_n),
    .gate_array_init_n(ga_n));
  pccc_far_side #(.SLOW(1'b1)) far (
    .mclk(mclk), .sw_on(sw_on), .rst_press(rst_press), .plug(plug), .jumper(jumper),
    .batt_low(batt_low), .low_volt(low_volt), .main_charge_mode(main_mode),
    .power_switch_irq_in(pwr_sw), .reset_switch_n(rst_sw_n), .adapter_present(adp),
    .charge_control_bypass(byp), .batt_at_or_below_5v(b5v), .low_voltage_detect(lvd),
    .normal_charging(nchg));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(6);
    nrst <= 1'b1;
    chk(pins, 32'h34);
    rdchk(OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1F);
    wt(3);
    chk(pins, 32'h5F);
    rdchk(OFS_CTRL, 32'h1F);
    rdchk(5'h14, 32'h0);
    rst_press <= 1'b1;
    wt(8);
    chk(pins, 32'h1D);
    rst_press <= 1'b0;
    wt(8);
    chk(pins, 32'h5F);
    rdchk(OFS_IRQ_STAT, 32'h10);
    bus(1'b1, OFS_IRQ_STAT, 32'h3F);
    sw_on <= 1'b1;
    wt(8);
    rdchk(OFS_IRQ_STAT, 32'h01);
    sw_on <= 1'b0;
    wt(8);
    rdchk(OFS_IRQ_STAT, 32'h03);
    bus(1'b1, OFS_IRQ_MASK, 32'h02);
    wt(3);
    chk(32'(irq), 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h02);
    wt(3);
    chk(32'(irq), 32'h0);
    rdchk(OFS_IRQ_STAT, 32'h01);
    bus(1'b1, OFS_IRQ_STAT, 32'h01);
    // eight hour interval, logic power off; aux timer runs alongside
    bus(1'b1, OFS_CTRL, 32'h1E);
    plug <= 1'b1;
    low_volt <= 1'b1;
    wt(8);
    chk(pins, 32'h6B);
    chk(32'(nchg), 32'h1);
    rdchk(OFS_STATUS, 32'h06);
    wt(28700);
    chk(pins, 32'h6B);
    wt(200);
    chk(pins, 32'h7F);
    rdchk(OFS_CHG_SEC, 32'h7080);
    rdchk(OFS_IRQ_STAT, 32'h24);
    jumper <= 1'b1;
    wt(8);
    chk(pins, 32'h7B);
    chk(32'(nchg), 32'h1);
    jumper <= 1'b0;
    wt(8);
    chk(pins, 32'h7F);
    chk(32'(nchg), 32'h0);
    batt_low <= 1'b1;
    wt(8);
    chk(pins, 32'h7B);
    plug <= 1'b0;
    batt_low <= 1'b0;
    wt(8);
    chk(pins, 32'h7F);
    rdchk(OFS_IRQ_STAT, 32'h2C);
    // eleven hour interval, logic power on at connect
    bus(1'b1, OFS_CTRL, 32'h1F);
    plug <= 1'b1;
    wt(8);
    chk(pins, 32'h5B);
    wt(28900);
    chk(pins, 32'h5B);
    wt(10800);
    chk(pins, 32'h5F);
    conclude();
  end
endmodule : test_power_charge_port_controller
